//--- rtl/uart_rx_fifo_flow_control.sv
// Receive holding register, receive FIFO and automatic flow control of one UART channel.
// Summary of operation
// - Receive FIFO holds 128 words of 8 data bits plus 3 error tags.
// - With FIFO enabled, the holding byte shows the oldest FIFO character.
// - Reading the holding byte pops; line status bits 2-4 show the new head's tags.
// - Automatic request control needs enhanced bit 6 and starts once modem bit 1 is set.
// - Request output goes high when fill reaches the trigger level above the programmed, or 32 above level 28.
// - Request output goes low again when fill drains to the level below.
// - Characters are still stored while request is off, until the FIFO is full.
// - Request deassertion sets status bit 5 when enable bit 6 is on.
// - Data interrupt at programmed level; request off and on at hysteresis limits.
// - Automatic clear control uses enhanced bit 7; clear low permits, high pauses.
// - Clear high holds the transmitter after its current character; low resumes it.
// - Clear going high sets status bit 5 when enable bit 7 is on.
// - A received pause character or pair holds transmission after the current character.
// - Pause match sets flag and interrupt if enabled; resume match restarts, clears bit 4.
// - Reset clears the four flow control character registers to zero.
// - Double mode compares two consecutive characters with the first and second values.
// - Recognised flow control characters never enter the host FIFO.
// - Pause characters are sent two character times after fill crosses the trigger.
// - Resume characters are sent once fill drops to one trigger level below.
// - Trigger levels 8, 16, 24, 28 resume at fills 0, 8, 16, 24.
// - FIFO control selects the trigger level that fires the data interrupt.
`timescale 1ns/1ps
module uart_rx_fifo_flow_control (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Host register port.
  input  wire logic [2:0] addr,
  input  wire logic       rd_stb,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            irq,
  // Receiver core.
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic [2:0] rx_err,
  // Transmitter core.
  input  wire logic       char_tick,
  output logic            tx_hold,
  output logic            inject_valid,
  output logic      [7:0] inject_data,
  input  wire logic       inject_ready,
  // Modem lines.
  input  wire logic       cts_n,
  output logic            rts_n
);
  import uart_rxfc_pkg::*;

  typedef enum {FC_IDLE, FC_WAIT, FC_OFF1, FC_OFF2, FC_HELD, FC_ON1, FC_ON2} fc_state_e;

  logic [7:0] ien_r;
  logic [7:0] lcr_r;
  logic [7:0] mdm_r;
  logic [7:0] feat_r;
  logic [7:0] fctl_r;
  logic [7:0] on_first_r;
  logic [7:0] on_second_r;
  logic [7:0] off_first_r;
  logic [7:0] off_second_r;
  logic       overrun_r;
  logic       int_flow_r;
  logic       int_xoff_r;
  logic       rts_off_r;
  logic       cts_prev_r;
  logic       sw_pause_r;
  logic [1:0] tick_cnt_r;
  fc_state_e  fc_r;
  fc_state_e  fc_nxt;

  logic              bank;
  logic              wr_ien;
  logic              wr_fctl;
  logic              rd_hold;
  logic              rd_ist;
  logic              rd_lst;
  logic              flush;
  logic              m_push;
  logic [WORD_W-1:0] m_word;
  logic              on_hit;
  logic              off_hit;
  logic [WORD_W-1:0] head_word;
  logic [7:0]        fill;
  logic              empty;
  logic              full;
  logic              push;
  logic              pop;
  logic [1:0]        sel;
  logic [7:0]        lvl;
  logic [7:0]        upper;
  logic [7:0]        lower;
  logic              auto_rts;
  logic              auto_cts;
  logic              rx_int;
  logic              rts_event;
  logic              cts_event;
  logic [1:0]        txm;
  logic [7:0]        ist_val;
  logic [7:0]        lst_val;

  assign bank    = (lcr_r == LCR_ENH_KEY);
  assign wr_ien  = wr_stb && !bank && addr == OFS_INT_EN;
  assign wr_fctl = wr_stb && !bank && addr == OFS_FIFO_STAT;
  assign rd_hold = rd_stb && !bank && addr == OFS_HOLD_BYTE;
  assign rd_ist  = rd_stb && !bank && addr == OFS_FIFO_STAT;
  assign rd_lst  = rd_stb && addr == OFS_LINE_STAT;
  assign flush   = wr_fctl && (wdata[FCTL_RX_FLUSH] || wdata[FCTL_FIFO_EN] != fctl_r[FCTL_FIFO_EN]);

  assign sel   = fctl_r[FCTL_TRIG_LO +: 2];
  assign lvl   = trig_level(sel);
  assign upper = trig_upper(sel);
  assign lower = trig_lower(sel);
  assign txm   = feat_r[FEAT_TXM_LO +: 2];

  // Configuration registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ien_r  <= RST_REG8;
      lcr_r  <= RST_REG8;
      mdm_r  <= RST_REG8;
      feat_r <= RST_REG8;
      fctl_r <= RST_REG8;
    end else if (wr_stb) begin
      if (addr == OFS_LINE_CTRL) begin
        lcr_r <= wdata;
      end else if (bank) begin
        if (addr == OFS_FIFO_STAT) begin
          feat_r <= wdata;
        end
      end else if (wr_ien) begin
        // The upper enables stay locked until the enhanced bit is set.
        ien_r <= feat_r[FEAT_ENH] ? wdata : {ien_r[7:4], wdata[3:0]};
      end else if (wr_fctl) begin
        fctl_r <= {wdata[7:2], 1'b0, wdata[0]};
      end else if (addr == OFS_MODEM) begin
        mdm_r <= wdata;
      end
    end
  end

  // Flow control character registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_first_r   <= RST_FLOW_C;
      on_second_r  <= RST_FLOW_C;
      off_first_r  <= RST_FLOW_C;
      off_second_r <= RST_FLOW_C;
    end else if (wr_stb && bank) begin
      unique case (addr)
        OFS_ON_FIRST:  on_first_r   <= wdata;
        OFS_ON_SECOND: on_second_r  <= wdata;
        OFS_OFF_FIRST: off_first_r  <= wdata;
        OFS_OFF_SEC:   off_second_r <= wdata;
        default: ;
      endcase
    end
  end

  flow_char_match u_match (
    .clk        (clk),
    .arst_n     (arst_n),
    .rx_valid   (rx_valid),
    .rx_word    ({rx_err, rx_data}),
    .mode       (feat_r[FEAT_RXM_LO +: 2]),
    .on_first   (on_first_r),
    .on_second  (on_second_r),
    .off_first  (off_first_r),
    .off_second (off_second_r),
    .push_v     (m_push),
    .push_word  (m_word),
    .on_hit     (on_hit),
    .off_hit    (off_hit)
  );

  // Without the FIFO enabled the store acts as a single holding byte.
  assign full  = fill >= (fctl_r[FCTL_FIFO_EN] ? FIFO_FULL_CNT : NOFIFO_FULL);
  assign empty = (fill == 8'h00);
  assign push  = m_push && !full;
  assign pop   = rd_hold && !empty;

  rx_word_fifo u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .flush     (flush),
    .push      (push),
    .push_word (m_word),
    .pop       (pop),
    .head_word (head_word),
    .fill      (fill)
  );

  // Overrun marks a character lost to a full store.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_r <= 1'b0;
    end else if (m_push && full) begin
      overrun_r <= 1'b1;
    end else if (rd_lst) begin
      overrun_r <= 1'b0;
    end
  end

  // Automatic request control with hysteresis.
  assign auto_rts  = feat_r[FEAT_AUTO_RTS] && mdm_r[MDM_RTS];
  assign rts_event = auto_rts && !rts_off_r && fill >= upper;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_off_r <= 1'b0;
    end else if (!auto_rts) begin
      rts_off_r <= 1'b0;
    end else if (fill >= upper) begin
      rts_off_r <= 1'b1;
    end else if (fill <= lower) begin
      rts_off_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= !(mdm_r[MDM_RTS] && !rts_off_r);
    end
  end

  // Clear input watch for the status flag.
  assign auto_cts  = feat_r[FEAT_AUTO_CTS];
  assign cts_event = auto_cts && cts_n && !cts_prev_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_prev_r <= 1'b1;
    end else begin
      cts_prev_r <= cts_n;
    end
  end

  // Software pause state from received characters.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_pause_r <= 1'b0;
    end else if (feat_r[FEAT_RXM_LO +: 2] == CM_NONE) begin
      sw_pause_r <= 1'b0;
    end else if (off_hit) begin
      sw_pause_r <= 1'b1;
    end else if (on_hit) begin
      sw_pause_r <= 1'b0;
    end
  end

  // The transmitter core only samples this level between characters, so a hold never cuts one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_hold <= 1'b0;
    end else begin
      tx_hold <= (auto_cts && cts_n) || sw_pause_r;
    end
  end

  // Status flags; a new event in the clearing cycle wins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_flow_r <= 1'b0;
    end else if ((rts_event && ien_r[IEN_RTS]) || (cts_event && ien_r[IEN_CTS])) begin
      int_flow_r <= 1'b1;
    end else if (rd_ist) begin
      int_flow_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_xoff_r <= 1'b0;
    end else if (off_hit && ien_r[IEN_XOFF]) begin
      int_xoff_r <= 1'b1;
    end else if (on_hit) begin
      int_xoff_r <= 1'b0;
    end
  end

  assign rx_int = ien_r[IEN_RX_DATA] && (fctl_r[FCTL_FIFO_EN] ? fill >= lvl : !empty);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= rx_int || int_flow_r || int_xoff_r;
    end
  end

  // Sending of pause and resume characters.
  always_comb begin
    fc_nxt = fc_r;
    unique case (fc_r)
      FC_IDLE: begin
        if (fill >= lvl) begin
          fc_nxt = FC_WAIT;
        end
      end
      FC_WAIT: begin
        if (char_tick && tick_cnt_r == PAUSE_DELAY_CHARS - 2'h1) begin
          fc_nxt = (txm == CM_SECOND) ? FC_OFF2 : FC_OFF1;
        end
      end
      FC_OFF1: begin
        if (inject_ready) begin
          fc_nxt = (txm == CM_BOTH) ? FC_OFF2 : FC_HELD;
        end
      end
      FC_OFF2: begin
        if (inject_ready) begin
          fc_nxt = FC_HELD;
        end
      end
      FC_HELD: begin
        if (fill <= lower) begin
          fc_nxt = (txm == CM_SECOND) ? FC_ON2 : FC_ON1;
        end
      end
      FC_ON1: begin
        if (inject_ready) begin
          fc_nxt = (txm == CM_BOTH) ? FC_ON2 : FC_IDLE;
        end
      end
      FC_ON2: begin
        if (inject_ready) begin
          fc_nxt = FC_IDLE;
        end
      end
    endcase
    if (txm == CM_NONE) begin
      fc_nxt = FC_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fc_r        <= FC_IDLE;
      tick_cnt_r  <= 2'h0;
      inject_data <= 8'h00;
    end else begin
      fc_r <= fc_nxt;
      if (fc_r != FC_WAIT) begin
        tick_cnt_r <= 2'h0;
      end else if (char_tick) begin
        tick_cnt_r <= tick_cnt_r + 2'h1;
      end
      unique case (fc_nxt)
        FC_OFF1: inject_data <= off_first_r;
        FC_OFF2: inject_data <= off_second_r;
        FC_ON1:  inject_data <= on_first_r;
        FC_ON2:  inject_data <= on_second_r;
        default: inject_data <= inject_data;
      endcase
    end
  end

  assign inject_valid = (fc_r == FC_OFF1) || (fc_r == FC_OFF2) || (fc_r == FC_ON1) || (fc_r == FC_ON2);

  // Read data.
  assign ist_val = {2'b00, int_flow_r, int_xoff_r, 1'b0, rx_int, 1'b0, !irq};
  assign lst_val = {3'b000, empty ? 3'b000 : head_word[10:8], overrun_r, !empty};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (addr == OFS_LINE_CTRL) begin
        rdata <= lcr_r;
      end else if (addr == OFS_LINE_STAT) begin
        rdata <= lst_val;
      end else if (bank) begin
        unique case (addr)
          OFS_FIFO_STAT: rdata <= feat_r;
          OFS_ON_FIRST:  rdata <= on_first_r;
          OFS_OFF_FIRST: rdata <= off_first_r;
          OFS_OFF_SEC:   rdata <= off_second_r;
          default:       rdata <= 8'h00;
        endcase
      end else begin
        unique case (addr)
          OFS_HOLD_BYTE: rdata <= empty ? 8'h00 : head_word[7:0];
          OFS_INT_EN:    rdata <= ien_r;
          OFS_FIFO_STAT: rdata <= ist_val;
          OFS_MODEM:     rdata <= mdm_r;
          default:       rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

//--- rtl/uart_rxfc_pkg.sv
// Constants, register map and trigger tables for the receive FIFO and flow control block.
package uart_rxfc_pkg;
  // Register offsets on the three-bit host address.
  localparam logic [2:0] OFS_HOLD_BYTE = 3'h0;
  localparam logic [2:0] OFS_INT_EN    = 3'h1;
  localparam logic [2:0] OFS_FIFO_STAT = 3'h2;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFS_MODEM     = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_ON_FIRST  = 3'h4;
  localparam logic [2:0] OFS_ON_SECOND = 3'h5;
  localparam logic [2:0] OFS_OFF_FIRST = 3'h6;
  localparam logic [2:0] OFS_OFF_SEC   = 3'h7;
  // Line control value that opens the enhanced bank.
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
  // Field positions.
  localparam int FCTL_FIFO_EN  = 0;
  localparam int FCTL_RX_FLUSH = 1;
  localparam int FCTL_TRIG_LO  = 6;
  localparam int FEAT_RXM_LO   = 0;
  localparam int FEAT_TXM_LO   = 2;
  localparam int FEAT_ENH      = 4;
  localparam int FEAT_AUTO_RTS = 6;
  localparam int FEAT_AUTO_CTS = 7;
  localparam int MDM_RTS       = 1;
  localparam int IEN_RX_DATA   = 0;
  localparam int IEN_XOFF      = 5;
  localparam int IEN_RTS       = 6;
  localparam int IEN_CTS       = 7;
  // Reset values.
  localparam logic [7:0] RST_REG8   = 8'h00;
  localparam logic [7:0] RST_FLOW_C = 8'h00;
  // FIFO geometry.
  localparam int FIFO_DEPTH = 128;
  localparam int WORD_W     = 11;
  localparam logic [7:0] FIFO_FULL_CNT = 8'h80;
  localparam logic [7:0] NOFIFO_FULL   = 8'h01;
  // Character times between crossing the trigger and sending the pause characters.
  localparam logic [1:0] PAUSE_DELAY_CHARS = 2'h2;

  typedef enum logic [1:0] {CM_NONE, CM_FIRST, CM_SECOND, CM_BOTH} char_mode_e;

  function automatic logic [7:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = 8'h08;
      2'h1: trig_level = 8'h10;
      2'h2: trig_level = 8'h18;
      2'h3: trig_level = 8'h1c;
    endcase
  endfunction

  function automatic logic [7:0] trig_upper(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_upper = 8'h10;
      2'h1: trig_upper = 8'h18;
      2'h2: trig_upper = 8'h1c;
      2'h3: trig_upper = 8'h20;
    endcase
  endfunction

  function automatic logic [7:0] trig_lower(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_lower = 8'h00;
      2'h1: trig_lower = 8'h08;
      2'h2: trig_lower = 8'h10;
      2'h3: trig_lower = 8'h18;
    endcase
  endfunction
endpackage

//--- rtl/rx_word_fifo.sv
// Receive FIFO of data bytes with their error tags.
`timescale 1ns/1ps
module rx_word_fifo (
  // Clock and reset.
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  // Control.
  input  wire logic                              flush,
  input  wire logic                              push,
  input  wire logic [uart_rxfc_pkg::WORD_W-1:0] push_word,
  input  wire logic                              pop,
  // Status and head word.
  output logic      [uart_rxfc_pkg::WORD_W-1:0] head_word,
  output logic      [7:0]                        fill
);
  import uart_rxfc_pkg::*;

  logic [WORD_W-1:0] mem [FIFO_DEPTH];
  logic [6:0]        wr_ptr_r;
  logic [6:0]        rd_ptr_r;
  logic [7:0]        fill_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= push_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= 7'h00;
      rd_ptr_r <= 7'h00;
      fill_r   <= 8'h00;
    end else if (flush) begin
      wr_ptr_r <= 7'h00;
      rd_ptr_r <= 7'h00;
      fill_r   <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 7'h01;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 7'h01;
      end
      if (push && !pop) begin
        fill_r <= fill_r + 8'h01;
      end else if (pop && !push) begin
        fill_r <= fill_r - 8'h01;
      end
    end
  end

  // The head is read straight from the array so a pop shows the next entry at once.
  assign head_word = mem[rd_ptr_r];
  assign fill      = fill_r;
endmodule

//--- rtl/flow_char_match.sv
// Recognises received resume and pause characters and strips them from the data stream.
`timescale 1ns/1ps
module flow_char_match (
  // Clock and reset.
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  // Received characters.
  input  wire logic                              rx_valid,
  input  wire logic [uart_rxfc_pkg::WORD_W-1:0] rx_word,
  // Configuration.
  input  wire logic [1:0]                        mode,
  input  wire logic [7:0]                        on_first,
  input  wire logic [7:0]                        on_second,
  input  wire logic [7:0]                        off_first,
  input  wire logic [7:0]                        off_second,
  // Filtered stream and hits.
  output logic                                   push_v,
  output logic      [uart_rxfc_pkg::WORD_W-1:0] push_word,
  output logic                                   on_hit,
  output logic                                   off_hit
);
  import uart_rxfc_pkg::*;

  logic [WORD_W-1:0] pend_r;
  logic              pend_v_r;
  logic              pend_off_r;
  logic [WORD_W-1:0] queue_r;
  logic              queue_v_r;
  logic [7:0]        c;

  assign c = rx_word[7:0];

  // A broken pair frees the held first character now and a new character that is no first value a cycle later.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r     <= '0;
      pend_v_r   <= 1'b0;
      pend_off_r <= 1'b0;
      queue_r    <= '0;
      queue_v_r  <= 1'b0;
      push_v     <= 1'b0;
      push_word  <= '0;
      on_hit     <= 1'b0;
      off_hit    <= 1'b0;
    end else begin
      push_v  <= 1'b0;
      on_hit  <= 1'b0;
      off_hit <= 1'b0;
      if (queue_v_r) begin
        queue_v_r <= 1'b0;
        push_v    <= 1'b1;
        push_word <= queue_r;
      end
      if (rx_valid) begin
        unique case (char_mode_e'(mode))
          CM_NONE: begin
            push_v    <= 1'b1;
            push_word <= rx_word;
          end
          CM_FIRST, CM_SECOND: begin
            if (c == (mode == CM_FIRST ? off_first : off_second)) begin
              off_hit <= 1'b1;
            end else if (c == (mode == CM_FIRST ? on_first : on_second)) begin
              on_hit <= 1'b1;
            end else begin
              push_v    <= 1'b1;
              push_word <= rx_word;
            end
          end
          CM_BOTH: begin
            if (pend_v_r && c == (pend_off_r ? off_second : on_second)) begin
              pend_v_r <= 1'b0;
              off_hit  <= pend_off_r;
              on_hit   <= !pend_off_r;
            end else begin
              if (pend_v_r) begin
                push_v    <= 1'b1;
                push_word <= pend_r;
              end
              if (c == off_first || c == on_first) begin
                pend_v_r   <= 1'b1;
                pend_r     <= rx_word;
                pend_off_r <= (c == off_first);
              end else if (pend_v_r) begin
                pend_v_r  <= 1'b0;
                queue_v_r <= 1'b1;
                queue_r   <= rx_word;
              end else begin
                push_v    <= 1'b1;
                push_word <= rx_word;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

//--- sim/uart_rx_fifo_flow_control_checker.sv
// Port-level assertions for the receive FIFO and flow control block.
`timescale 1ns/1ps
module uart_rx_fifo_flow_control_checker (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       arst_n,
  // Host port.
  input wire logic       rd_stb,
  input wire logic       wr_stb,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  // Core and modem side.
  input wire logic       rx_valid,
  input wire logic       char_tick,
  input wire logic       tx_hold,
  input wire logic       inject_valid,
  input wire logic [7:0] inject_data,
  input wire logic       inject_ready,
  input wire logic       cts_n,
  input wire logic       rts_n
);
  logic [2:0] calm_r;
  logic [2:0] calm_inj_r;
  // Outputs may only move soon after an input event, so a path that never settles is caught.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      calm_r <= 3'h0;
      calm_inj_r <= 3'h0;
    end else begin
      calm_r <= (rx_valid || rd_stb || wr_stb || $changed(cts_n)) ? 3'h0 : calm_r + {2'h0, calm_r != 3'h7};
      calm_inj_r <= (char_tick || rd_stb || wr_stb || inject_ready) ? 3'h0 : calm_inj_r + {2'h0, calm_inj_r != 3'h7};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rdata_holds; !rd_stb |=> $stable(rdata); endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("rdata moved");
  property p_inj_holds; inject_valid && !inject_ready |=> inject_valid && $stable(inject_data); endproperty
  a_inj_holds: assert property (p_inj_holds) else $error("inject dropped");
  property p_rst_lines; $rose(arst_n) |-> rts_n && !tx_hold && !inject_valid && !irq; endproperty
  a_rst_lines: assert property (p_rst_lines) else $error("reset lines");
  property p_rst_rdata; $rose(arst_n) |-> rdata == 8'h00; endproperty
  a_rst_rdata: assert property (p_rst_rdata) else $error("reset rdata");
  property p_rts_calm; calm_r == 3'h7 |-> $stable(rts_n); endproperty
  a_rts_calm: assert property (p_rts_calm) else $error("rts moved");
  property p_hold_calm; calm_r == 3'h7 |-> $stable(tx_hold); endproperty
  a_hold_calm: assert property (p_hold_calm) else $error("hold moved");
  property p_irq_calm; calm_r == 3'h7 |-> $stable(irq); endproperty
  a_irq_calm: assert property (p_irq_calm) else $error("irq moved");
  property p_inj_cause; $rose(inject_valid) |-> calm_inj_r < 3'h6; endproperty
  a_inj_cause: assert property (p_inj_cause) else $error("inject uncaused");
endmodule

//--- sim/remote_uart.sv
// Remote UART model: sends characters, paces character times and takes injected bytes.
`timescale 1ns/1ps
module remote_uart (
  // Clock.
  input  wire logic       clk,
  // Block side.
  input  wire logic       rts_n,
  input  wire logic       inject_valid,
  input  wire logic [7:0] inject_data,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic      [2:0] rx_err,
  output logic            char_tick,
  output logic            inject_ready
);
  logic [4:0] tick_r = 5'h00;
  logic [7:0] got_q[$];
  logic       obey = 1'b1;
  assign char_tick = tick_r == 5'h1f;
  // Ready comes and goes, so the block must hold its byte while it waits.
  assign inject_ready = tick_r[1];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_err = 3'h0;
  end
  always @(posedge clk) begin
    tick_r <= tick_r + 5'h01;
    if (inject_valid && inject_ready) begin
      got_q.push_back(inject_data);
    end
  end
  task automatic send(input logic [7:0] d, input logic [2:0] e);
    int n = 0;
    while (obey && rts_n && n < 500) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #2;
    rx_valid = 1'b1;
    rx_data = d;
    rx_err = e;
    @(posedge clk);
    #2;
    rx_valid = 1'b0;
    rx_data = ~d;
    rx_err = ~e;
    repeat (4) @(posedge clk);
  endtask
endmodule

//--- sim/uart_rx_fifo_flow_control_test.sv
// Self-checking bench for the receive FIFO and flow control block.
`timescale 1ns/1ps
module uart_rx_fifo_flow_control_test;
  import uart_rxfc_pkg::*;
  logic       clk, arst_n, rd_stb, wr_stb, irq, rx_valid, char_tick, tx_hold;
  logic       inject_valid, inject_ready, cts_n, rts_n;
  logic [2:0] addr, rx_err, mon;
  logic [7:0] wdata, rdata, rx_data, inject_data;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cyc = 0;
  assign mon = {irq, tx_hold, rts_n};
  uart_rx_fifo_flow_control u_dut (.*);
  remote_uart u_rem (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The run needs about 2000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(posedge clk);
    #2;
    wr_stb = 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk);
    #2;
    addr = a;
    rd_stb = 1'b1;
    @(posedge clk);
    #2;
    rd_stb = 1'b0;
    chk(rdata & m, exp);
  endtask
  task automatic feat(input logic [7:0] d);
    wr(OFS_LINE_CTRL, LCR_ENH_KEY);
    wr(OFS_FIFO_STAT, d);
    wr(OFS_LINE_CTRL, 8'h03);
  endtask
  task automatic pin(input int k, input logic e);
    repeat (4) @(posedge clk);
    #2;
    chk({7'h00, mon[k]}, {7'h00, e});
  endtask
  task automatic wait_got(input int n);
    int k = 0;
    while (u_rem.got_q.size() < n && k < 300) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    addr = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wdata = 8'h00;
    cts_n = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    arst_n = 1'b1;
    wr(OFS_LINE_CTRL, LCR_ENH_KEY);
    rc(OFS_ON_FIRST, 8'hff, 8'h00);
    rc(OFS_OFF_SEC, 8'hff, 8'h00);
    wr(OFS_OFF_FIRST, 8'h13);
    wr(OFS_ON_FIRST, 8'h11);
    wr(OFS_OFF_SEC, 8'h93);
    rc(OFS_OFF_SEC, 8'hff, 8'h93);
    wr(OFS_LINE_CTRL, 8'h03);
    wr(OFS_INT_EN, 8'hc1);
    rc(OFS_INT_EN, 8'hff, 8'h01);
    feat(8'h50);
    wr(OFS_INT_EN, 8'h41);
    wr(OFS_FIFO_STAT, 8'h41);
    pin(0, 1'b1);
    wr(OFS_MODEM, 8'h02);
    pin(0, 1'b0);
    u_rem.obey = 1'b0;
    for (int i = 0; i < 129; i++) begin
      u_rem.send(8'(i + 1), 3'(i));
      if (i == 14 || i == 15) pin(2, i == 15);
      if (i == 22 || i == 23) pin(0, i == 23);
    end
    rc(OFS_FIFO_STAT, 8'h25, 8'h24);
    rc(OFS_LINE_STAT, 8'h1f, 8'h03);
    for (int i = 0; i < 128; i++) begin
      if (i == 119 || i == 120) pin(0, i == 119);
      rc(OFS_LINE_STAT, 8'h1c, {3'h0, 3'(i), 2'h0});
      rc(OFS_HOLD_BYTE, 8'hff, 8'(i + 1));
    end
    u_rem.obey = 1'b1;
    feat(8'h90);
    wr(OFS_INT_EN, 8'h80);
    cts_n = 1'b1;
    pin(1, 1'b1);
    rc(OFS_FIFO_STAT, 8'h20, 8'h20);
    cts_n = 1'b0;
    pin(1, 1'b0);
    feat(8'h11);
    wr(OFS_INT_EN, 8'h20);
    u_rem.send(8'h13, 3'h0);
    pin(1, 1'b1);
    pin(2, 1'b1);
    rc(OFS_FIFO_STAT, 8'h10, 8'h10);
    u_rem.send(8'h11, 3'h0);
    pin(1, 1'b0);
    rc(OFS_FIFO_STAT, 8'h10, 8'h00);
    feat(8'h13);
    u_rem.send(8'h13, 3'h0);
    pin(1, 1'b0);
    u_rem.send(8'h93, 3'h0);
    pin(1, 1'b1);
    u_rem.send(8'h11, 3'h0);
    u_rem.send(8'h00, 3'h0);
    pin(1, 1'b0);
    rc(OFS_LINE_STAT, 8'h01, 8'h00);
    feat(8'h14);
    wr(OFS_FIFO_STAT, 8'h01);
    for (int i = 0; i < 8; i++) u_rem.send(8'h40 + 8'(i), 3'h0);
    chk(8'(u_rem.got_q.size()), 8'h00);
    wait_got(1);
    chk(u_rem.got_q[0], 8'h13);
    for (int i = 0; i < 7; i++) rc(OFS_HOLD_BYTE, 8'hff, 8'h40 + 8'(i));
    wait_got(2);
    chk(8'(u_rem.got_q.size()), 8'h01);
    rc(OFS_HOLD_BYTE, 8'hff, 8'h47);
    wait_got(2);
    chk(u_rem.got_q[1], 8'h11);
    wr(OFS_FIFO_STAT, 8'h00);
    u_rem.send(8'h55, 3'h0);
    u_rem.send(8'h66, 3'h0);
    rc(OFS_LINE_STAT, 8'h03, 8'h03);
    rc(OFS_HOLD_BYTE, 8'hff, 8'h55);
    summarize();
  end
endmodule
bind uart_rx_fifo_flow_control uart_rx_fifo_flow_control_checker u_chk (.*);
